//--- logic/tpwm_consts.svh
// register offsets, field positions, reset values and codes of the triggered pwm timer
`ifndef TPWM_CONSTS_SVH
`define TPWM_CONSTS_SVH

// ==========================================================
// register byte offsets
`define TPWM_OFS_CTL0 8'h00
`define TPWM_OFS_CTL1 8'h04
`define TPWM_OFS_IOC0 8'h08
`define TPWM_OFS_IOC1 8'h0c
`define TPWM_OFS_IOC2 8'h10
`define TPWM_OFS_OPT0 8'h14
`define TPWM_OFS_CNT 8'h18
`define TPWM_OFS_CCR0 8'h1c
`define TPWM_OFS_STEP 8'h04

// ==========================================================
// field positions
`define TPWM_CE_BIT 0
`define TPWM_CKS_LO 1
`define TPWM_CKS_HI 3
`define TPWM_MD_LO 0
`define TPWM_MD_HI 2
`define TPWM_EEE_BIT 5
`define TPWM_EST_BIT 6
`define TPWM_ETS_LO 0
`define TPWM_ETS_HI 1
`define TPWM_EES_LO 2
`define TPWM_EES_HI 3

// ==========================================================
// values
`define TPWM_MODE_TRIG 3'h2
`define TPWM_CTL1_WMASK 8'hbf
`define TPWM_RST_REG8 8'h00
`define TPWM_RST_REG16 16'h0000
`define TPWM_CNT_IDLE 16'hffff
`define TPWM_CNT_ZERO 16'h0000
`define TPWM_RESP_OKAY 2'h0
`define TPWM_RESP_SLVERR 2'h2

`endif

//--- logic/tpwm_pkg.sv
// types shared by the triggered pwm timer
package tpwm_pkg;

	// ==========================================================
	// counter state
	typedef enum logic [0:0] {
		TPWM_WAIT = 1'b0,
		TPWM_RUN = 1'b1
	} tpwm_state_type;

	// ==========================================================
	// axi4-lite carriers
	typedef struct packed {
		logic [7:0] awaddr;
		logic awvalid;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic wvalid;
		logic bready;
		logic [7:0] araddr;
		logic arvalid;
		logic rready;
	} tpwm_axi_req_type;

	typedef struct packed {
		logic awready;
		logic wready;
		logic [1:0] bresp;
		logic bvalid;
		logic arready;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic rvalid;
	} tpwm_axi_rsp_type;

endpackage : tpwm_pkg

//--- logic/tpwm_timer.sv
// triggered pwm timer with axi4-lite register slave
//
// Implementation choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/100ps
`include "tpwm_consts.svh"

// Notes on behaviour
// RULE1: lower width value interrupts once per cycle
// RULE2: width value above cycle never interrupts
// RULE3: mode field 010 selects triggered pwm
// RULE4: enabled counter waits idle for trigger
// RULE5: trigger moves counter ffff to 0, outputs start
// RULE6: trigger while running clears and restarts counter
// RULE7: trigger toggles square, drives pwm active
// RULE8: software trigger bit acts as trigger edge
// RULE9: square output toggles once per period
// RULE10: active width equals width value counts
// RULE11: period equals cycle value plus one
// RULE12: cycle interrupt and clear step after match
// RULE13: width interrupt when counter equals value
// RULE14: buffers reload only at cycle match clear (the code also loads them when the counter is enabled)
// RULE15: reload armed only by width a write
// RULE16: software writes width a last
// RULE17: per output enable and level bits
// RULE18: software keeps unused square enable zero
// RULE19: event enable selects count source
// RULE20: two-bit edge selects for trigger, event
// RULE21: counter read returns live counter
// RULE22: capture and overflow registers have no effect
// RULE23: software waits cycle interrupt before rewrite
// RULE24: zero gives 0 percent, cycle plus one 100
// RULE25: trigger edge acts at next count step
module tpwm_timer (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire tpwm_pkg::tpwm_axi_req_type axi_req,
	output tpwm_pkg::tpwm_axi_rsp_type axi_rsp,
	// pins in
	input wire logic trig_pin,
	input wire logic event_pin,
	// pins out
	output logic square_wave_out,
	output logic pwm_out_a,
	output logic pwm_out_b,
	output logic pwm_out_c,
	// event pulses
	output logic cycle_match_irq,
	output logic [2:0] width_match_irq
);
	import tpwm_pkg::*;

	// ==========================================================
	// axi4-lite slave
	logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
	logic [1:0] bresp_q, rresp_q;
	logic [31:0] rdata_q, rd_word;
	logic aw_hold_q, w_hold_q;
	logic [7:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0] w_strb_q;
	logic rd_hit;

	wire aw_take = axi_req.awvalid & awready_q;
	wire w_take = axi_req.wvalid & wready_q;
	wire ar_take = axi_req.arvalid & arready_q;
	wire have_aw = aw_hold_q | aw_take;
	wire have_w = w_hold_q | w_take;
	wire do_wr = have_aw & have_w;
	wire [7:0] wr_addr = aw_hold_q ? aw_addr_q : axi_req.awaddr;
	wire [31:0] wr_data = w_hold_q ? w_data_q : axi_req.wdata;
	wire [3:0] wr_strb = w_hold_q ? w_strb_q : axi_req.wstrb;
	wire bvalid_d = do_wr | (bvalid_q & ~axi_req.bready);
	wire rvalid_d = ar_take | (rvalid_q & ~axi_req.rready);

	// write decode
	wire wr_ctl0 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_CTL0);
	wire wr_ctl1 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_CTL1);
	wire wr_ioc0 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_IOC0);
	wire wr_ioc1 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_IOC1);
	wire wr_ioc2 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_IOC2);
	wire wr_opt0 = do_wr & wr_strb[0] & (wr_addr == `TPWM_OFS_OPT0);
	wire [3:0] wr_ccr;
	wire [3:0] ccr_addr_hit;
	wire wr_mapped;

	genvar gk;
	generate
		for (gk = 0; gk < 4; gk++) begin : g_ccr_dec
			assign ccr_addr_hit[gk] = (wr_addr == (`TPWM_OFS_CCR0 + 8'(gk * 4)));
			assign wr_ccr[gk] = do_wr & ccr_addr_hit[gk];
		end
	endgenerate

	// the counter read buffer is read-only, so a write there is refused
	assign wr_mapped = (wr_addr <= `TPWM_OFS_OPT0) | (|ccr_addr_hit);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b0;
			wready_q <= 1'b0;
			arready_q <= 1'b0;
			bvalid_q <= 1'b0;
			rvalid_q <= 1'b0;
			bresp_q <= `TPWM_RESP_OKAY;
			rresp_q <= `TPWM_RESP_OKAY;
			rdata_q <= 32'h00000000;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			aw_addr_q <= 8'h00;
			w_data_q <= 32'h00000000;
			w_strb_q <= 4'h0;
		end else begin
			aw_hold_q <= have_aw & ~do_wr;
			w_hold_q <= have_w & ~do_wr;
			awready_q <= ~(have_aw & ~do_wr) & ~bvalid_d;
			wready_q <= ~(have_w & ~do_wr) & ~bvalid_d;
			arready_q <= ~rvalid_d;
			bvalid_q <= bvalid_d;
			rvalid_q <= rvalid_d;
			if (aw_take) begin
				aw_addr_q <= axi_req.awaddr;
			end
			if (w_take) begin
				w_data_q <= axi_req.wdata;
				w_strb_q <= axi_req.wstrb;
			end
			if (do_wr) begin
				bresp_q <= wr_mapped ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
			end
			if (ar_take) begin
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? `TPWM_RESP_OKAY : `TPWM_RESP_SLVERR;
			end
		end
	end

	assign axi_rsp.awready = awready_q;
	assign axi_rsp.wready = wready_q;
	assign axi_rsp.bvalid = bvalid_q;
	assign axi_rsp.bresp = bresp_q;
	assign axi_rsp.arready = arready_q;
	assign axi_rsp.rvalid = rvalid_q;
	assign axi_rsp.rdata = rdata_q;
	assign axi_rsp.rresp = rresp_q;

	// ==========================================================
	// registers
	logic [7:0] ctl0_q, ctl1_q, ioc0_q, ioc1_q, ioc2_q, opt0_q;
	logic [15:0] ccr_q [4];
	logic [15:0] buf_q [4];
	logic [15:0] cnt_q, cnt_d;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctl0_q <= `TPWM_RST_REG8;
			ctl1_q <= `TPWM_RST_REG8;
			ioc0_q <= `TPWM_RST_REG8;
			ioc1_q <= `TPWM_RST_REG8;
			ioc2_q <= `TPWM_RST_REG8;
			opt0_q <= `TPWM_RST_REG8;
			for (int i = 0; i < 4; i++) begin
				ccr_q[i] <= `TPWM_RST_REG16;
			end
		end else begin
			if (wr_ctl0) ctl0_q <= wr_data[7:0];
			// the trigger bit is a strobe and always reads back as zero
			if (wr_ctl1) ctl1_q <= wr_data[7:0] & `TPWM_CTL1_WMASK; // RULE8
			if (wr_ioc0) ioc0_q <= wr_data[7:0];
			// stored for software only, never read by the counter
			if (wr_ioc1) ioc1_q <= wr_data[7:0]; // RULE22
			if (wr_opt0) opt0_q <= wr_data[7:0]; // RULE22
			if (wr_ioc2) ioc2_q <= wr_data[7:0];
			for (int i = 0; i < 4; i++) begin
				if (wr_ccr[i]) begin
					ccr_q[i][15:8] <= wr_strb[1] ? wr_data[15:8] : ccr_q[i][15:8];
					ccr_q[i][7:0] <= wr_strb[0] ? wr_data[7:0] : ccr_q[i][7:0];
				end
			end
		end
	end

	// read decode
	always_comb begin
		rd_word = 32'h00000000;
		rd_hit = 1'b1;
		if (axi_req.araddr == `TPWM_OFS_CTL0) begin
			rd_word[7:0] = ctl0_q;
		end else if (axi_req.araddr == `TPWM_OFS_CTL1) begin
			rd_word[7:0] = ctl1_q;
		end else if (axi_req.araddr == `TPWM_OFS_IOC0) begin
			rd_word[7:0] = ioc0_q;
		end else if (axi_req.araddr == `TPWM_OFS_IOC1) begin
			rd_word[7:0] = ioc1_q;
		end else if (axi_req.araddr == `TPWM_OFS_IOC2) begin
			rd_word[7:0] = ioc2_q;
		end else if (axi_req.araddr == `TPWM_OFS_OPT0) begin
			rd_word[7:0] = opt0_q;
		end else if (axi_req.araddr == `TPWM_OFS_CNT) begin
			rd_word[15:0] = cnt_q; // RULE21
		end else if (axi_req.araddr == `TPWM_OFS_CCR0) begin
			rd_word[15:0] = ccr_q[0];
		end else if (axi_req.araddr == `TPWM_OFS_CCR0 + `TPWM_OFS_STEP) begin
			rd_word[15:0] = ccr_q[1];
		end else if (axi_req.araddr == `TPWM_OFS_CCR0 + 8'h08) begin
			rd_word[15:0] = ccr_q[2];
		end else if (axi_req.araddr == `TPWM_OFS_CCR0 + 8'h0c) begin
			rd_word[15:0] = ccr_q[3];
		end else begin
			rd_hit = 1'b0;
		end
	end

	// ==========================================================
	// pin synchronisers and edge detection
	logic trig_meta_q, trig_sync_q, trig_prev_q;
	logic ev_meta_q, ev_sync_q, ev_prev_q;
	logic [7:0] presc_q;

	function automatic logic edge_hit(input logic [1:0] sel, input logic prev, input logic cur);
		edge_hit = (sel[0] & ~prev & cur) | (sel[1] & prev & ~cur);
	endfunction : edge_hit

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			trig_meta_q <= 1'b0;
			trig_sync_q <= 1'b0;
			trig_prev_q <= 1'b0;
			ev_meta_q <= 1'b0;
			ev_sync_q <= 1'b0;
			ev_prev_q <= 1'b0;
			presc_q <= 8'h00;
		end else begin
			trig_meta_q <= trig_pin;
			trig_sync_q <= trig_meta_q;
			trig_prev_q <= trig_sync_q;
			ev_meta_q <= event_pin;
			ev_sync_q <= ev_meta_q;
			ev_prev_q <= ev_sync_q;
			presc_q <= presc_q + 8'h01;
		end
	end

	wire trig_hit = edge_hit(ioc2_q[`TPWM_ETS_HI:`TPWM_ETS_LO], trig_prev_q, trig_sync_q); // RULE20
	wire ev_hit = edge_hit(ioc2_q[`TPWM_EES_HI:`TPWM_EES_LO], ev_prev_q, ev_sync_q); // RULE20
	wire [7:0] presc_mask = ~(8'hff << ctl0_q[`TPWM_CKS_HI:`TPWM_CKS_LO]);
	wire presc_tick = ((presc_q & presc_mask) == presc_mask);

	// ==========================================================
	// counter, buffers and waveforms
	tpwm_state_type state_q, state_d;
	logic active_q, trig_pend_q, reload_q, sq_q;
	logic [2:0] act_q, act_d;
	logic square_q, cyc_irq_q;
	logic [2:0] pwm_q, wid_irq_q;
	logic [15:0] cmp_buf [4];

	wire active = ctl0_q[`TPWM_CE_BIT] & (ctl1_q[`TPWM_MD_HI:`TPWM_MD_LO] == `TPWM_MODE_TRIG); // RULE3
	wire step = active & (ctl1_q[`TPWM_EEE_BIT] ? ev_hit : presc_tick); // RULE19
	wire sw_trig = wr_ctl1 & wr_data[`TPWM_EST_BIT]; // RULE8
	wire trig_any = trig_pend_q | trig_hit | sw_trig; // RULE25
	wire running = (state_q == TPWM_RUN);
	wire at_end = running & (cnt_q == buf_q[0]);
	wire restart = step & trig_any; // RULE5 RULE6
	wire wrap = step & ~trig_any & at_end; // RULE12 RULE11
	wire moved = restart | wrap | (step & running);
	wire start = active & ~active_q;
	wire load_now = start | (wrap & reload_q); // RULE14 RULE15
	wire [2:0] wmatch;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		if (!active) begin
			state_d = TPWM_WAIT;
			cnt_d = `TPWM_CNT_IDLE; // RULE4
		end else if (restart) begin
			state_d = TPWM_RUN;
			cnt_d = `TPWM_CNT_ZERO; // RULE5 RULE6
		end else if (wrap) begin
			cnt_d = `TPWM_CNT_ZERO; // RULE12
		end else if (step & running) begin
			cnt_d = cnt_q + 16'h0001;
		end
	end

	generate
		for (gk = 0; gk < 4; gk++) begin : g_cmp
			assign cmp_buf[gk] = load_now ? ccr_q[gk] : buf_q[gk];
		end
		for (gk = 0; gk < 3; gk++) begin : g_width
			// a match beats the trigger's set, so a zero width stays inactive
			assign wmatch[gk] = active & moved & (cnt_d == cmp_buf[gk + 1]); // RULE13 RULE1 RULE24
			assign act_d[gk] = wmatch[gk] ? 1'b0 :
				(restart | wrap) ? 1'b1 : (active & act_q[gk]); // RULE7 RULE10
		end
	endgenerate

	wire sq_d = ioc0_q[0] ? (sq_q ^ (restart | wrap)) : ioc0_q[1]; // RULE7 RULE9 RULE17

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_q <= TPWM_WAIT;
			cnt_q <= `TPWM_CNT_IDLE;
			active_q <= 1'b0;
			trig_pend_q <= 1'b0;
			reload_q <= 1'b0;
			act_q <= 3'h0;
			sq_q <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				buf_q[i] <= `TPWM_RST_REG16;
			end
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			active_q <= active;
			trig_pend_q <= active & trig_any & ~step; // RULE25
			// a fresh width a write wins over the reload that consumes the old one
			reload_q <= wr_ccr[1] | (reload_q & ~(wrap & reload_q)); // RULE15
			act_q <= act_d;
			sq_q <= sq_d;
			for (int i = 0; i < 4; i++) begin
				buf_q[i] <= cmp_buf[i]; // RULE14
			end
		end
	end

	// registered pins and pulses
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			square_q <= 1'b0;
			pwm_q <= 3'h0;
			cyc_irq_q <= 1'b0;
			wid_irq_q <= 3'h0;
		end else begin
			square_q <= sq_d;
			for (int i = 0; i < 3; i++) begin
				pwm_q[i] <= ioc0_q[2 * i + 2] & (act_d[i] ^ ioc0_q[2 * i + 3]); // RULE17
			end
			cyc_irq_q <= wrap; // RULE12
			wid_irq_q <= wmatch; // RULE13 RULE2
		end
	end

	assign square_wave_out = square_q;
	assign pwm_out_a = pwm_q[0];
	assign pwm_out_b = pwm_q[1];
	assign pwm_out_c = pwm_q[2];
	assign cycle_match_irq = cyc_irq_q;
	assign width_match_irq = wid_irq_q;

	// ==========================================================
	// checks
	a_idle_hold: assert property (@(posedge aclk) disable iff (!aresetn)
		!active |=> (cnt_q == `TPWM_CNT_IDLE) && (state_q == TPWM_WAIT)) // RULE4
		else $error("counter not idle while disabled");
	a_mode_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(ctl1_q[2:0] != 3'h2) |=> !running && !cyc_irq_q) // RULE3
		else $error("counter ran outside triggered mode");
	a_trig_restart: assert property (@(posedge aclk) disable iff (!aresetn)
		restart |=> (cnt_q == 16'h0000) && running && !cyc_irq_q) // RULE5
		else $error("trigger did not restart counter");
	a_cycle_wrap: assert property (@(posedge aclk) disable iff (!aresetn)
		(running && active && step && !trig_any && cnt_q == buf_q[0])
		|=> cyc_irq_q && (cnt_q == 16'h0000)) // RULE12
		else $error("cycle match did not clear counter");
	a_width_same: assert property (@(posedge aclk) disable iff (!aresetn)
		wid_irq_q[0] |-> (cnt_q == buf_q[1]) && (!pwm_q[0] || ioc0_q[3])) // RULE13
		else $error("width pulse not at counter equality");
	a_width_above: assert property (@(posedge aclk) disable iff (!aresetn)
		(running && buf_q[3] > buf_q[0] && cnt_q <= buf_q[0]) |-> !wid_irq_q[2]) // RULE2
		else $error("width pulse above cycle value");
	a_square_flip: assert property (@(posedge aclk) disable iff (!aresetn)
		((restart || wrap) && ioc0_q[0] && !wr_ioc0)
		|=> square_wave_out != $past(square_wave_out)) // RULE7
		else $error("square output did not toggle");
	a_reload_gate: assert property (@(posedge aclk) disable iff (!aresetn)
		(active_q && !reload_q) |=> buf_q[0] == $past(buf_q[0])) // RULE15
		else $error("buffer reloaded without width a write");
	a_cnt_read: assert property (@(posedge aclk) disable iff (!aresetn)
		(ar_take && axi_req.araddr == 8'h18) |=> rdata_q[15:0] == $past(cnt_q)) // RULE21
		else $error("counter read mismatch");
	a_idle_level: assert property (@(posedge aclk) disable iff (!aresetn)
		!active |=> pwm_out_a == ($past(ioc0_q[2]) & $past(ioc0_q[3]))) // RULE17
		else $error("pwm idle level wrong");

endmodule : tpwm_timer

//--- tb/tpwm_far_model.sv
// far side of the timer: external trigger source and event source
`timescale 1ns/100ps

module tpwm_far_model (
	// clock
	input wire logic aclk,
	// pins driven into the timer
	output logic trig_pin,
	output logic event_pin
);

	// ==========================================================
	// idle levels
	initial begin
		trig_pin = 1'b0;
		event_pin = 1'b0;
	end

	// ==========================================================
	// trigger: held six clocks so the synchroniser sees it at any phase
	task automatic pulse_trig();
		@(posedge aclk);
		trig_pin <= 1'b1;
		repeat (6) @(posedge aclk);
		trig_pin <= 1'b0;
	endtask : pulse_trig

	// ==========================================================
	// events: only the falling edge is the valid one in the bench setup
	task automatic pulse_events(input int n);
		repeat (n) begin
			@(posedge aclk);
			event_pin <= 1'b1;
			repeat (4) @(posedge aclk);
			event_pin <= 1'b0;
			repeat (4) @(posedge aclk);
		end
	endtask : pulse_events

endmodule : tpwm_far_model

//--- tb/tb_triggered_pwm_timer.sv
// self-checking bench of the triggered pwm timer
`timescale 1ns/100ps
`include "tpwm_consts.svh"

module tb_triggered_pwm_timer;
	import tpwm_pkg::*;

	// ==========================================================
	// signals
	logic aclk;
	logic aresetn;
	tpwm_axi_req_type req;
	tpwm_axi_rsp_type rsp;
	logic trig_pin;
	logic event_pin;
	logic square_wave_out;
	logic pwm_out_a;
	logic pwm_out_b;
	logic pwm_out_c;
	logic cycle_match_irq;
	logic [2:0] width_match_irq;
	int errors = 0;
	int checks_done = 0;
	int cyc = 0;
	int k;
	integer seed = 32'h0678;
	logic [31:0] r;
	logic [1:0] bq [$];
	logic [33:0] rq [$];
	localparam logic [1:0] ok_r = `TPWM_RESP_OKAY;
	localparam logic [1:0] err_r = `TPWM_RESP_SLVERR;
	// counts per 40 clocks: sq toggles, c high, b high, a high, irq c, b, a, cycle
	localparam logic [7:0][7:0] e_one = {8'h0a, 8'h14, 8'h00, 8'h0a, {4{8'h0a}}};
	localparam logic [7:0][7:0] e_two = {8'h0a, 8'h00, 8'h00, 8'h0a, 8'h00, {3{8'h0a}}};
	// halved count clock: five periods of eight clocks in the same window
	localparam logic [7:0][7:0] e_three = {8'h05, 8'h00, 8'h00, 8'h0a, 8'h00, {3{8'h05}}};

	// ==========================================================
	// instances
	tpwm_timer u_dut (
		.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp),
		.trig_pin(trig_pin), .event_pin(event_pin), .square_wave_out(square_wave_out),
		.pwm_out_a(pwm_out_a), .pwm_out_b(pwm_out_b), .pwm_out_c(pwm_out_c),
		.cycle_match_irq(cycle_match_irq), .width_match_irq(width_match_irq)
	);

	tpwm_far_model u_far (.aclk(aclk), .trig_pin(trig_pin), .event_pin(event_pin));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	// ==========================================================
	// checking and reporting
	task automatic chk(input logic [33:0] got, input logic [33:0] exp);
		checks_done++;
		if (got !== exp) begin
			errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : tally_and_finish

	task automatic endt(input string s);
		$display("test %s done", s);
	endtask : endt

	// responses are matched against the oldest note of the requester
	always @(posedge aclk) begin
		if (rsp.bvalid && req.bready) chk(34'(rsp.bresp), 34'(bq.pop_front()));
		if (rsp.rvalid && req.rready) chk({rsp.rresp, rsp.rdata}, rq.pop_front());
	end

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			errors++;
			tally_and_finish();
		end
	end

	// ==========================================================
	// bus tasks; the extra edge at the end keeps two requests from sharing a step
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		logic done;
		bq.push_back(e);
		req.awaddr <= a;
		req.wdata <= d;
		req.wstrb <= 4'hf;
		req.awvalid <= 1'b1;
		req.wvalid <= 1'b1;
		req.bready <= 1'b1;
		done = 1'b0;
		while (!done) begin
			@(posedge aclk);
			if (rsp.awready) req.awvalid <= 1'b0;
			if (rsp.wready) req.wvalid <= 1'b0;
			done = rsp.bvalid;
		end
		req.bready <= 1'b0;
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		rq.push_back({e, d});
		req.araddr <= a;
		req.arvalid <= 1'b1;
		req.rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (rsp.arready) req.arvalid <= 1'b0;
		end while (!rsp.rvalid);
		req.rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	// ==========================================================
	// waveform counting over a window of forty clocks
	task automatic measure(input logic [7:0][7:0] e);
		logic [7:0][7:0] m;
		logic [7:0] ev;
		logic sq;
		m = '0;
		sq = square_wave_out;
		repeat (40) begin
			@(posedge aclk);
			ev = {sq ^ square_wave_out, pwm_out_c, pwm_out_b, pwm_out_a, width_match_irq,
				cycle_match_irq};
			sq = square_wave_out;
			for (int i = 0; i < 8; i++) m[i] = m[i] + 8'(ev[i]);
		end
		for (int i = 0; i < 8; i++) chk(34'(m[i]), 34'(e[i]));
	endtask : measure

	// a rewrite waits for the cycle pulse, then width a arms the reload
	task automatic rearm();
		k = 0;
		while (cycle_match_irq !== 1'b1 && k < 64) begin
			@(posedge aclk);
			k++;
		end
		// a missing cycle pulse counts as a failure, and width a is still written
		if (k == 64) errors++;
		wr(8'h20, 32'h1, ok_r);
		repeat (12) @(posedge aclk);
	endtask : rearm

	// ==========================================================
	// main sequence
	initial begin
		req = '0;
		aresetn = 1'b0;
		repeat (20) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd(`TPWM_OFS_CNT, 32'hffff, ok_r);
		rd(`TPWM_OFS_CTL0, 32'h0, ok_r);
		rd(`TPWM_OFS_CCR0, 32'h0, ok_r);
		wr(8'h40, 32'h5a, err_r);
		rd(8'h40, 32'h0, err_r);
		wr(`TPWM_OFS_CNT, 32'h1, err_r);
		endt("registers");
		// mode 000 must ignore a software trigger
		wr(`TPWM_OFS_CTL0, 32'h1, ok_r);
		wr(`TPWM_OFS_CTL1, 32'h40, ok_r);
		rd(`TPWM_OFS_CNT, 32'hffff, ok_r);
		wr(`TPWM_OFS_CTL0, 32'h0, ok_r);
		wr(`TPWM_OFS_IOC0, 32'h0, ok_r);
		wr(`TPWM_OFS_IOC2, 32'h9, ok_r);
		wr(`TPWM_OFS_CCR0, 32'h10, ok_r);
		wr(`TPWM_OFS_CTL1, 32'h22, ok_r);
		wr(`TPWM_OFS_CTL0, 32'h1, ok_r);
		rd(`TPWM_OFS_CNT, 32'hffff, ok_r);
		u_far.pulse_trig();
		u_far.pulse_events(5);
		repeat (6) @(posedge aclk);
		rd(`TPWM_OFS_CNT, 32'h4, ok_r);
		u_far.pulse_trig();
		u_far.pulse_events(1);
		repeat (6) @(posedge aclk);
		rd(`TPWM_OFS_CNT, 32'h0, ok_r);
		endt("events");
		// cycle 3, a 1, b 0 (0 percent), c 2 active low
		wr(`TPWM_OFS_CTL0, 32'h0, ok_r);
		wr(`TPWM_OFS_CTL1, 32'h2, ok_r);
		wr(`TPWM_OFS_CCR0, 32'h3, ok_r);
		wr(8'h24, 32'h0, ok_r);
		wr(8'h28, 32'h2, ok_r);
		wr(8'h20, 32'h1, ok_r);
		wr(`TPWM_OFS_IOC0, 32'hd5, ok_r);
		wr(`TPWM_OFS_CTL0, 32'h1, ok_r);
		wr(`TPWM_OFS_CTL1, 32'h42, ok_r);
		rd(`TPWM_OFS_CTL1, 32'h2, ok_r);
		repeat (8) @(posedge aclk);
		measure(e_one);
		endt("pwm");
		for (int i = 0; i < 2; i++) begin
			r = $random(seed);
			wr(i ? `TPWM_OFS_OPT0 : `TPWM_OFS_IOC1, r, ok_r);
			rd(i ? `TPWM_OFS_OPT0 : `TPWM_OFS_IOC1, {24'h0, r[7:0]}, ok_r);
		end
		rearm();
		measure(e_one);
		wr(8'h28, 32'h7, ok_r);
		repeat (12) @(posedge aclk);
		measure(e_one);
		rearm();
		measure(e_two);
		endt("reload");
		// clock select 1 stretches every count step to two clocks
		wr(`TPWM_OFS_CTL0, 32'h3, ok_r);
		repeat (16) @(posedge aclk);
		measure(e_three);
		endt("prescaler");
		tally_and_finish();
	end

endmodule : tb_triggered_pwm_timer
